// [logic/dco_cmd_handler.sv]
// Configuration overlay command handler: subcommand decode, freeze lock, identify and set.
// Behaviour
// RULE_01: Command code B1h enters overlay subcommands.
// RULE_02: Features C0h-C3h select restore, freeze, identify, set.
// RULE_03: Reserved feature value aborts with ABT and ERR.
// RULE_04: Restore drops overlay, full capabilities return.
// RULE_05: After freeze, all four subcommands abort.
// RULE_06: Freeze survives resets, cleared only by power-down.
// RULE_07: Identify sends 512 bytes by PIO data-in.
// RULE_08: Identify structure always shows full capabilities.
// RULE_09: Set clears capability bits; cleared features unsupported.
// RULE_10: Overlay bits not offered are ignored.
// RULE_11: Set violation aborts with reason, word, bit.
// RULE_12: Max LBA change with protected area: 06h/03h.
// RULE_13: Disabling enabled security aborts: 04h/07h/08h.
// RULE_14: Word 1 holds multiword DMA modes.
// RULE_15: Word 2 holds Ultra DMA modes.
// RULE_16: Word 7 holds nine feature bits.
// RULE_17: Last word: signature A5h low, checksum high.
// RULE_18: Checksum makes all structure bytes sum zero.
`timescale 1ns/1ps
`default_nettype none
module dco_cmd_handler
   import dco_pkg::*;
(
   // Clock, protocol reset and power-on reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic por_n,
   // Command block
   input wire logic cmd_valid,
   input wire dco_cmd_s cmd,
   output logic cmd_ready,
   // PIO data-in stream to host
   output logic rd_valid,
   output logic [15:0] rd_data,
   input wire logic rd_ready,
   // PIO data-out stream from host
   input wire logic wr_valid,
   input wire logic [15:0] wr_data,
   output logic wr_ready,
   // Completion
   output logic done,
   output dco_result_s result,
   output logic [7:0] status,
   // Drive state seen by the overlay
   input wire logic hpa_established,
   input wire logic security_enabled,
   // Full capability set of the product
   input wire logic [DCO_MDMA_W-1:0] full_mdma,
   input wire logic [DCO_UDMA_W-1:0] full_udma,
   input wire logic [DCO_FEAT_W-1:0] full_feat,
   input wire logic [DCO_LBA_W-1:0] full_lba,
   // Capabilities reported by identify-device
   output logic [DCO_MDMA_W-1:0] cap_mdma,
   output logic [DCO_UDMA_W-1:0] cap_udma,
   output logic [DCO_FEAT_W-1:0] cap_feat,
   output logic [DCO_LBA_W-1:0] cap_lba,
   output logic overlay_active,
   output logic frozen
);
   logic rst_s_n;
   logic por_s_n;
   dco_state_e state_reg, state_next;
   logic [7:0] idx_reg, idx_next;
   logic rd_valid_reg, rd_valid_next;
   logic [15:0] rd_data_reg, rd_data_next;
   logic done_reg, done_next;
   dco_result_s result_reg, result_next;
   logic [DCO_MDMA_W-1:0] rx_mdma_reg, rx_mdma_next;
   logic [DCO_UDMA_W-1:0] rx_udma_reg, rx_udma_next;
   logic [DCO_FEAT_W-1:0] rx_feat_reg, rx_feat_next;
   logic [DCO_LBA_W-1:0] rx_lba_reg, rx_lba_next;
   logic freeze_reg, freeze_next;
   logic mod_reg, mod_next;
   logic [DCO_MDMA_W-1:0] ovl_mdma_reg, ovl_mdma_next;
   logic [DCO_UDMA_W-1:0] ovl_udma_reg, ovl_udma_next;
   logic [DCO_FEAT_W-1:0] ovl_feat_reg, ovl_feat_next;
   logic [DCO_LBA_W-1:0] ovl_lba_reg, ovl_lba_next;
   logic [7:0] gen_idx;
   logic [15:0] gen_word;
   logic [DCO_LBA_W-1:0] new_lba;
   dco_result_s ok_res;

   dco_rst_sync u_rst_sync (
      .core_clk(core_clk),
      .arst_n(rst_n),
      .srst_n(rst_s_n)
   );

   dco_rst_sync u_por_sync (
      .core_clk(core_clk),
      .arst_n(por_n),
      .srst_n(por_s_n)
   );

   // The generator is fed with the full set, never the overlay. [RULE_08]
   dco_ovl_gen u_gen (
      .idx(gen_idx),
      .mdma(full_mdma),
      .udma(full_udma),
      .feat(full_feat),
      .lba(full_lba),
      .word(gen_word)
   );

   function automatic dco_result_s abort_res(input logic [7:0] rsn, input logic [7:0] hi,
                                             input logic [7:0] lo);
      dco_result_s r;
      r = '0;
      r.status[DCO_ST_RDY] = 1'b1;
      r.status[DCO_ST_ERR] = 1'b1;
      r.error[DCO_ER_ABT] = 1'b1;
      r.sec_cnt = rsn;
      r.cyl_hi = hi;
      r.cyl_lo = lo;
      return r;
   endfunction

   // A zero or larger-than-native maximum LBA cannot shrink the drive, so it keeps the native size.
   assign new_lba = (rx_lba_reg == '0 || rx_lba_reg > full_lba) ? full_lba : rx_lba_reg;

   always_comb
   begin
      state_next = state_reg;
      idx_next = idx_reg;
      rd_valid_next = rd_valid_reg;
      rd_data_next = rd_data_reg;
      done_next = 1'b0;
      result_next = result_reg;
      rx_mdma_next = rx_mdma_reg;
      rx_udma_next = rx_udma_reg;
      rx_feat_next = rx_feat_reg;
      rx_lba_next = rx_lba_reg;
      freeze_next = freeze_reg;
      mod_next = mod_reg;
      ovl_mdma_next = ovl_mdma_reg;
      ovl_udma_next = ovl_udma_reg;
      ovl_feat_next = ovl_feat_reg;
      ovl_lba_next = ovl_lba_reg;
      ok_res = '0;
      ok_res.status[DCO_ST_RDY] = 1'b1;
      gen_idx = idx_reg;
      case (state_reg)
         DCO_IDLE:
         begin
            gen_idx = DCO_W_REV;
            if (cmd_valid && cmd.code == DCO_CMD_CODE) // [RULE_01]
            begin
               done_next = 1'b1;
               result_next = ok_res;
               if (cmd.feature < DCO_SUB_RESTORE || cmd.feature > DCO_SUB_SET) // [RULE_02]
               begin
                  result_next = abort_res(DCO_RSN_BAD_SUB, DCO_ZERO8, DCO_ZERO8); // [RULE_03]
               end
               else if (freeze_reg)
               begin
                  result_next = abort_res(DCO_RSN_FROZEN, DCO_ZERO8, DCO_ZERO8); // [RULE_05]
               end
               else if (cmd.feature == DCO_SUB_FREEZE)
               begin
                  freeze_next = 1'b1; // [RULE_05]
               end
               else if (cmd.feature == DCO_SUB_IDENTIFY)
               begin
                  done_next = 1'b0;
                  state_next = DCO_SEND; // [RULE_07]
                  idx_next = DCO_W_REV;
                  rd_valid_next = 1'b1;
                  rd_data_next = gen_word;
               end
               else if (cmd.feature == DCO_SUB_SET)
               begin
                  if (mod_reg)
                  begin
                     result_next = abort_res(DCO_RSN_MODIFIED, DCO_ZERO8, DCO_ZERO8); // [RULE_11]
                  end
                  else
                  begin
                     done_next = 1'b0;
                     state_next = DCO_RECV;
                     idx_next = DCO_W_REV;
                  end
               end
               else if (hpa_established && cap_lba != full_lba)
               begin
                  result_next = abort_res(DCO_RSN_PROTECTED, DCO_W_LBA0, DCO_ZERO8); // [RULE_12]
               end
               else
               begin
                  mod_next = 1'b0; // [RULE_04]
                  ovl_mdma_next = full_mdma;
                  ovl_udma_next = full_udma;
                  ovl_feat_next = full_feat;
                  ovl_lba_next = full_lba;
               end
            end
         end
         DCO_SEND:
         begin
            gen_idx = idx_reg + 8'h01;
            if (rd_ready)
            begin
               if (idx_reg == DCO_LAST_WORD) // [RULE_07]
               begin
                  rd_valid_next = 1'b0;
                  state_next = DCO_IDLE;
                  done_next = 1'b1;
                  result_next = ok_res;
               end
               else
               begin
                  idx_next = idx_reg + 8'h01;
                  rd_data_next = gen_word;
               end
            end
         end
         DCO_RECV:
         begin
            if (wr_valid)
            begin
               if (idx_reg == DCO_W_MDMA)
               begin
                  rx_mdma_next = wr_data[DCO_MDMA_W-1:0];
               end
               if (idx_reg == DCO_W_UDMA)
               begin
                  rx_udma_next = wr_data[DCO_UDMA_W-1:0];
               end
               if (idx_reg >= DCO_W_LBA0 && idx_reg <= DCO_W_LBA3)
               begin
                  rx_lba_next[(idx_reg - DCO_W_LBA0) * 16 +: 16] = wr_data;
               end
               if (idx_reg == DCO_W_FEAT)
               begin
                  rx_feat_next = wr_data[DCO_FEAT_W-1:0];
               end
               idx_next = idx_reg + 8'h01;
               if (idx_reg == DCO_LAST_WORD)
               begin
                  state_next = DCO_EVAL;
               end
            end
         end
         DCO_EVAL:
         begin
            state_next = DCO_IDLE;
            done_next = 1'b1;
            result_next = ok_res;
            // Compare with the clipped value, since power-on leaves the raw overlay all ones.
            if (hpa_established && new_lba != cap_lba)
            begin
               result_next = abort_res(DCO_RSN_PROTECTED, DCO_W_LBA0, DCO_ZERO8); // [RULE_12]
            end
            else if (security_enabled && full_feat[DCO_FEAT_SECURITY] &&
                     !rx_feat_reg[DCO_FEAT_SECURITY])
            begin
               result_next = abort_res(DCO_RSN_DISABLE, DCO_W_FEAT, DCO_LO_SECURITY); // [RULE_13]
            end
            else
            begin
               // Bits the full set lacks cannot be turned on by masking with it. [RULE_10]
               ovl_mdma_next = rx_mdma_reg & full_mdma; // [RULE_09]
               ovl_udma_next = rx_udma_reg & full_udma;
               ovl_feat_next = rx_feat_reg & full_feat;
               ovl_lba_next = new_lba;
               mod_next = 1'b1;
            end
         end
         default:
         begin
            state_next = DCO_IDLE;
            rd_valid_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         state_reg <= DCO_IDLE;
         idx_reg <= 8'h00;
         rd_valid_reg <= 1'b0;
         rd_data_reg <= 16'h0000;
         done_reg <= 1'b0;
         result_reg <= '0;
         rx_mdma_reg <= '0;
         rx_udma_reg <= '0;
         rx_feat_reg <= '0;
         rx_lba_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         rd_valid_reg <= rd_valid_next;
         rd_data_reg <= rd_data_next;
         done_reg <= done_next;
         result_reg <= result_next;
         rx_mdma_reg <= rx_mdma_next;
         rx_udma_reg <= rx_udma_next;
         rx_feat_reg <= rx_feat_next;
         rx_lba_reg <= rx_lba_next;
      end
   end

   // Only power-on clears these; hardware and software resets leave them. [RULE_06]
   // Power-on loads all ones, which the clipped outputs report as the full set, since no overlay can be in force before the first set.
   always_ff @(posedge core_clk or negedge por_s_n)
   begin
      if (!por_s_n)
      begin
         freeze_reg <= 1'b0;
         mod_reg <= 1'b0;
         ovl_mdma_reg <= '1;
         ovl_udma_reg <= '1;
         ovl_feat_reg <= '1;
         ovl_lba_reg <= '1;
      end
      else
      begin
         freeze_reg <= freeze_next;
         mod_reg <= mod_next;
         ovl_mdma_reg <= ovl_mdma_next;
         ovl_udma_reg <= ovl_udma_next;
         ovl_feat_reg <= ovl_feat_next;
         ovl_lba_reg <= ovl_lba_next;
      end
   end

   assign cmd_ready = (state_reg == DCO_IDLE);
   assign rd_valid = rd_valid_reg;
   assign rd_data = rd_data_reg;
   assign wr_ready = (state_reg == DCO_RECV);
   assign done = done_reg;
   assign result = result_reg;
   assign status = {state_reg != DCO_IDLE, result_reg.status[6:4],
                    rd_valid_reg | wr_ready, result_reg.status[2:0]};
   // Outputs are clipped against the full set so power-on all-ones never overstates.
   assign cap_mdma = ovl_mdma_reg & full_mdma; // [RULE_09]
   assign cap_udma = ovl_udma_reg & full_udma;
   assign cap_feat = ovl_feat_reg & full_feat;
   assign cap_lba = (ovl_lba_reg > full_lba) ? full_lba : ovl_lba_reg;
   assign overlay_active = mod_reg;
   assign frozen = freeze_reg;
endmodule
`default_nettype wire

// [logic/dco_pkg.sv]
// Constants and carrier types shared by the configuration overlay command handler.
package dco_pkg;
   localparam logic [7:0] DCO_CMD_CODE = 8'hb1;
   localparam logic [7:0] DCO_SUB_RESTORE = 8'hc0;
   localparam logic [7:0] DCO_SUB_FREEZE = 8'hc1;
   localparam logic [7:0] DCO_SUB_IDENTIFY = 8'hc2;
   localparam logic [7:0] DCO_SUB_SET = 8'hc3;
   localparam logic [7:0] DCO_LAST_WORD = 8'hff;
   localparam logic [7:0] DCO_W_REV = 8'h00;
   localparam logic [7:0] DCO_W_MDMA = 8'h01;
   localparam logic [7:0] DCO_W_UDMA = 8'h02;
   localparam logic [7:0] DCO_W_LBA0 = 8'h03;
   localparam logic [7:0] DCO_W_LBA3 = 8'h06;
   localparam logic [7:0] DCO_W_FEAT = 8'h07;
   localparam logic [15:0] DCO_REVISION = 16'h0001;
   localparam logic [7:0] DCO_SIGNATURE = 8'ha5;
   localparam int DCO_MDMA_W = 3;
   localparam int DCO_UDMA_W = 6;
   localparam int DCO_FEAT_W = 9;
   localparam int DCO_LBA_W = 64;
   localparam int DCO_FEAT_SECURITY = 3;
   localparam logic [7:0] DCO_RSN_FROZEN = 8'h01;
   localparam logic [7:0] DCO_RSN_MODIFIED = 8'h03;
   localparam logic [7:0] DCO_RSN_DISABLE = 8'h04;
   localparam logic [7:0] DCO_RSN_PROTECTED = 8'h06;
   localparam logic [7:0] DCO_RSN_BAD_SUB = 8'h08;
   localparam logic [7:0] DCO_LO_SECURITY = 8'h08;
   localparam int DCO_ST_ERR = 0;
   localparam int DCO_ST_DRQ = 3;
   localparam int DCO_ST_RDY = 6;
   localparam int DCO_ST_BSY = 7;
   localparam int DCO_ER_ABT = 2;
   localparam logic [7:0] DCO_ZERO8 = 8'h00;

   typedef struct packed {
      logic [7:0] code;
      logic [7:0] feature;
   } dco_cmd_s;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] error;
      logic [7:0] sec_cnt;
      logic [7:0] cyl_hi;
      logic [7:0] cyl_lo;
   } dco_result_s;

   typedef enum logic [1:0] {
      DCO_IDLE,
      DCO_SEND,
      DCO_RECV,
      DCO_EVAL
   } dco_state_e;
endpackage

// [logic/dco_rst_sync.sv]
// Two-stage reset release synchroniser.
`timescale 1ns/1ps
`default_nettype none
module dco_rst_sync
   import dco_pkg::*;
(
   // Clock and raw reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Synchronised reset
   output logic srst_n
);
   logic meta_reg;
   logic hold_reg;

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_reg <= 1'b0;
         hold_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= 1'b1;
         hold_reg <= meta_reg;
      end
   end

   assign srst_n = hold_reg;
endmodule
`default_nettype wire

// [logic/dco_ovl_gen.sv]
// Word generator for the 512-byte overlay identify structure, checksum included.
`timescale 1ns/1ps
`default_nettype none
module dco_ovl_gen
   import dco_pkg::*;
(
   // Word select
   input wire logic [7:0] idx,
   // Full capability set
   input wire logic [DCO_MDMA_W-1:0] mdma,
   input wire logic [DCO_UDMA_W-1:0] udma,
   input wire logic [DCO_FEAT_W-1:0] feat,
   input wire logic [DCO_LBA_W-1:0] lba,
   // Selected word
   output logic [15:0] word
);
   logic [7:0] sum;
   logic [7:0] csum;

   // Reserved words and bits contribute zero bytes, so only the defined fields are summed.
   always_comb
   begin
      sum = DCO_REVISION[7:0] + DCO_REVISION[15:8];
      sum = sum + {5'h00, mdma};
      sum = sum + {2'h0, udma};
      sum = sum + feat[7:0] + {7'h00, feat[8]};
      for (int i = 0; i < DCO_LBA_W / 8; i++)
      begin
         sum = sum + lba[i*8 +: 8];
      end
      sum = sum + DCO_SIGNATURE;
      csum = 8'h00 - sum; // [RULE_18]
   end

   always_comb
   begin
      word = 16'h0000;
      if (idx == DCO_W_REV)
      begin
         word = DCO_REVISION;
      end
      else if (idx == DCO_W_MDMA)
      begin
         word = {13'h0000, mdma}; // [RULE_14]
      end
      else if (idx == DCO_W_UDMA)
      begin
         word = {10'h000, udma}; // [RULE_15]
      end
      else if (idx >= DCO_W_LBA0 && idx <= DCO_W_LBA3)
      begin
         word = lba[(idx - DCO_W_LBA0) * 16 +: 16];
      end
      else if (idx == DCO_W_FEAT)
      begin
         word = {7'h00, feat}; // [RULE_16]
      end
      else if (idx == DCO_LAST_WORD)
      begin
         word = {csum, DCO_SIGNATURE}; // [RULE_17]
      end
   end
endmodule
`default_nettype wire

// [test/dco_cmd_props.sv]
// Port assertions for the overlay command handler.
`timescale 1ns/1ps
`default_nettype none
module dco_cmd_props
   import dco_pkg::*;
(
   // Clock and resets
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic por_n,
   // Command and data-in words
   input wire logic cmd_valid,
   input wire dco_cmd_s cmd,
   input wire logic cmd_ready,
   input wire logic rd_valid,
   input wire logic [15:0] rd_data,
   input wire logic rd_ready,
   // Completion and state
   input wire logic done,
   input wire dco_result_s result,
   input wire logic [DCO_MDMA_W-1:0] full_mdma,
   input wire logic [DCO_FEAT_W-1:0] full_feat,
   input wire logic frozen
);
   logic take;
   logic sub_ok;
   logic [8:0] idx_reg;
   logic [8:0] idx_next;
   logic [7:0] sum_reg;
   logic [7:0] sum_next;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n || !por_n);
   assign take = cmd_valid && cmd_ready && (cmd.code == DCO_CMD_CODE);
   assign sub_ok = cmd.feature inside {DCO_SUB_RESTORE, DCO_SUB_FREEZE, DCO_SUB_IDENTIFY,
      DCO_SUB_SET};
   // Word index and byte sum of the data-in stream, cleared once it ends.
   always_comb
   begin
      idx_next = rd_valid ? idx_reg : 9'h000;
      sum_next = rd_valid ? sum_reg : 8'h00;
      if (rd_valid && rd_ready)
      begin
         idx_next = idx_reg + 9'h001;
         sum_next = sum_reg + rd_data[7:0] + rd_data[15:8];
      end
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         idx_reg <= 9'h000;
         sum_reg <= 8'h00;
      end
      else
      begin
         idx_reg <= idx_next;
         sum_reg <= sum_next;
      end
   end
   a_foreign_code: assert property (cmd_valid && cmd_ready && cmd.code != DCO_CMD_CODE |=> !done)
      else $error("foreign command code answered");
   a_bad_sub: assert property (take && !sub_ok |=> done && result.sec_cnt == 8'h08 && result.error == 8'h04 && result.status == 8'h41)
      else $error("reserved subcommand not aborted");
   a_freeze_lock: assert property (take && !frozen && cmd.feature == DCO_SUB_FREEZE |=> done && frozen && result.status == 8'h40)
      else $error("freeze lock not taken");
   a_frozen_abort: assert property (take && frozen && sub_ok |=> done && result.sec_cnt == 8'h01)
      else $error("frozen subcommand not aborted");
   a_frozen_kept: assert property (disable iff (!por_n) frozen |=> frozen)
      else $error("freeze lock lost without power-down");
   a_ident_start: assert property (take && !frozen && cmd.feature == DCO_SUB_IDENTIFY |=> rd_valid && rd_data == 16'h0001)
      else $error("identify stream did not start");
   a_word_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
      else $error("offered word changed before acceptance");
   a_word_count: assert property (rd_valid && rd_ready && idx_reg == 9'h0ff |=> !rd_valid && done)
      else $error("stream not closed after 256 words");
   a_mdma_word: assert property (rd_valid && idx_reg == 9'h001 |-> rd_data == {13'h0000, full_mdma})
      else $error("multiword DMA word wrong");
   a_feat_word: assert property (rd_valid && idx_reg == 9'h007 |-> rd_data == {7'h00, full_feat})
      else $error("feature word wrong");
   a_sign_sum: assert property (rd_valid && idx_reg == 9'h0ff |-> rd_data[7:0] == 8'ha5 && rd_data[15:8] == 8'h00 - sum_reg - 8'ha5)
      else $error("signature or checksum wrong");
endmodule
bind dco_cmd_handler dco_cmd_props props_u (.*);
`default_nettype wire

// [test/dco_host_model.sv]
// Host adapter model: issues commands and moves data words both ways, with stalls.
`timescale 1ns/1ps
`default_nettype none
module dco_host
   import dco_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Command block
   output logic cmd_valid,
   output dco_cmd_s cmd,
   input wire logic cmd_ready,
   // Data words
   input wire logic rd_valid,
   input wire logic [15:0] rd_data,
   output logic rd_ready,
   output logic wr_valid,
   output logic [15:0] wr_data,
   input wire logic wr_ready
);
   logic [15:0] rd_words [256];
   logic [15:0] wr_words [256];
   initial
   begin
      cmd_valid = 1'b0;
      cmd = 16'h0000;
      rd_ready = 1'b0;
      wr_valid = 1'b0;
      wr_data = 16'h0000;
   end
   task automatic issue(input logic [7:0] c, input logic [7:0] f);
      begin
         @(posedge core_clk);
         cmd_valid <= 1'b1;
         cmd <= {c, f};
         @(posedge core_clk);
         while (!cmd_ready)
            @(posedge core_clk);
         cmd_valid <= 1'b0;
         cmd <= ~cmd;
      end
   endtask
   task automatic read_block();
      int n;
      begin
         n = 0;
         while (n < 256)
         begin
            @(posedge core_clk);
            if (rd_valid && rd_ready)
            begin
               rd_words[n] = rd_data;
               n++;
            end
            rd_ready <= (n < 256) && ($urandom_range(3) != 0);
         end
      end
   endtask
   task automatic write_block();
      int n;
      begin
         n = 0;
         while (n < 256)
         begin
            @(posedge core_clk);
            if (wr_valid && wr_ready)
               n++;
            if (!wr_valid || wr_ready)
            begin
               if (n < 256 && $urandom_range(3) != 0)
               begin
                  wr_valid <= 1'b1;
                  wr_data <= wr_words[n];
               end
               else
               begin
                  // An idle bus toggles so a stale word is never mistaken for data.
                  wr_valid <= 1'b0;
                  wr_data <= ~wr_data;
               end
            end
         end
      end
   endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the overlay command handler.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import dco_pkg::*;
();
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic por_n = 1'b0;
   logic hpa_established = 1'b0;
   logic security_enabled = 1'b0;
   logic cmd_valid, cmd_ready, rd_valid, rd_ready, wr_valid, wr_ready, done, ovl, frozen;
   logic [15:0] rd_data, wr_data;
   logic [7:0] status;
   dco_cmd_s cmd;
   dco_result_s result;
   logic [DCO_MDMA_W-1:0] full_mdma, cap_mdma, rx_mdma, m_mdma;
   logic [DCO_UDMA_W-1:0] full_udma, cap_udma, rx_udma, m_udma;
   logic [DCO_FEAT_W-1:0] full_feat, cap_feat, rx_feat, m_feat;
   logic [DCO_LBA_W-1:0] full_lba, cap_lba, rx_lba, m_lba;
   logic m_frozen, m_ovl;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;
   always #10 core_clk = ~core_clk;
   dco_cmd_handler dut_u (.*, .overlay_active(ovl));
   dco_host host_u (.*);
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         stop_test();
      end
   end
   task automatic restart(input logic hw, input logic pw);
      rst_n <= !hw;
      por_n <= !pw;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      if (pw)
      begin
         {m_frozen, m_ovl} = 2'b00;
         {m_mdma, m_udma, m_feat, m_lba} = {full_mdma, full_udma, full_feat, full_lba};
      end
   endtask
   function automatic logic [15:0] exp_word(input int k);
      case (k)
         0: return 16'h0001;
         1: return {13'h0000, full_mdma};
         2: return {10'h000, full_udma};
         3, 4, 5, 6: return full_lba[16*(k-3) +: 16];
         7: return {7'h00, full_feat};
         default: return 16'h0000;
      endcase
   endfunction
   // Issues one subcommand and compares the outcome with the bench model.
   task automatic run(input logic [7:0] f);
      logic [7:0] sc, hi, lo, sum;
      logic [63:0] eff;
      logic [15:0] w;
      int k;
      foreach (host_u.wr_words[k])
         host_u.wr_words[k] = (k > 2 && k < 7) ? rx_lba[16*(k-3) +: 16] : 16'h0000;
      host_u.wr_words[1] = {13'h0000, rx_mdma};
      host_u.wr_words[2] = {10'h000, rx_udma};
      host_u.wr_words[7] = {7'h00, rx_feat};
      host_u.issue(DCO_CMD_CODE, f);
      eff = (rx_lba == 64'h0 || rx_lba > full_lba) ? full_lba : rx_lba;
      {sc, hi, lo} = 24'h000000;
      if (!(f inside {DCO_SUB_RESTORE, DCO_SUB_FREEZE, DCO_SUB_IDENTIFY, DCO_SUB_SET}))
         sc = 8'h08;
      else if (m_frozen)
         sc = 8'h01;
      else if (f == DCO_SUB_SET && m_ovl)
         sc = 8'h03;
      else if (hpa_established && ((f == DCO_SUB_RESTORE && m_lba != full_lba) ||
         (f == DCO_SUB_SET && eff != m_lba)))
         {sc, hi} = 16'h0603;
      else if (f == DCO_SUB_SET && security_enabled && full_feat[3] && !rx_feat[3])
         {sc, hi, lo} = 24'h040708;
      if (f == DCO_SUB_IDENTIFY && sc == 8'h00)
         host_u.read_block();
      if (f == DCO_SUB_SET && !m_frozen && !m_ovl)
         host_u.write_block();
      k = 0;
      while (done !== 1'b1 && k < 8)
      begin
         @(posedge core_clk);
         k++;
      end
      check("done", done, 1'b1);
      check("status", result.status, (sc != 8'h00) ? 8'h41 : 8'h40);
      check("error", result.error, (sc != 8'h00) ? 8'h04 : 8'h00);
      check("status_byte", status, (sc != 8'h00) ? 8'h41 : 8'h40);
      check("reason", result.sec_cnt, sc);
      check("word_bit", {result.cyl_hi, result.cyl_lo}, {hi, lo});
      if (f == DCO_SUB_IDENTIFY && sc == 8'h00)
      begin
         sum = 8'h00;
         for (k = 0; k < 255; k++)
         begin
            w = exp_word(k);
            sum = sum + w[7:0] + w[15:8];
            check("ident_word", host_u.rd_words[k], w);
         end
         check("last_word", host_u.rd_words[255], {8'h00 - sum - 8'ha5, 8'ha5});
      end
      if (sc == 8'h00 && f == DCO_SUB_FREEZE)
         m_frozen = 1'b1;
      if (sc == 8'h00 && f == DCO_SUB_RESTORE)
         {m_ovl, m_mdma, m_udma, m_feat, m_lba} = {1'b0, full_mdma, full_udma, full_feat, full_lba};
      if (sc == 8'h00 && f == DCO_SUB_SET)
         {m_ovl, m_mdma, m_udma, m_feat, m_lba} = {1'b1, rx_mdma & full_mdma,
            rx_udma & full_udma, rx_feat & full_feat, eff};
      @(posedge core_clk);
      check("frozen", frozen, m_frozen);
      check("overlay", ovl, m_ovl);
      check("caps", {cap_mdma, cap_udma, cap_feat}, {m_mdma, m_udma, m_feat});
      check("cap_lba", cap_lba, m_lba);
   endtask
   initial
   begin
      void'($urandom(53057));
      full_mdma = DCO_MDMA_W'($urandom);
      full_udma = DCO_UDMA_W'($urandom);
      full_feat = DCO_FEAT_W'($urandom) | 9'h008;
      full_lba = {$urandom, $urandom} | 64'h10000;
      {rx_mdma, rx_udma, rx_feat, rx_lba} = {full_mdma, full_udma, full_feat, full_lba};
      restart(1'b1, 1'b1);
      run(8'hbf);
      run(8'hc4);
      run(8'($urandom_range(8'hbf)));
      host_u.issue(8'hb0, DCO_SUB_FREEZE);
      @(posedge core_clk);
      check("foreign", {done, frozen}, 2'b00);
      rx_mdma = DCO_MDMA_W'($urandom);
      rx_udma = DCO_UDMA_W'($urandom);
      rx_feat = DCO_FEAT_W'($urandom);
      rx_lba = full_lba - 64'h1 - 64'($urandom_range(255));
      run(DCO_SUB_SET);
      run(DCO_SUB_IDENTIFY);
      run(DCO_SUB_SET);
      hpa_established <= 1'b1;
      run(DCO_SUB_RESTORE);
      hpa_established <= 1'b0;
      run(DCO_SUB_RESTORE);
      {rx_feat, rx_lba} = {full_feat & 9'h1f7, full_lba};
      security_enabled <= 1'b1;
      run(DCO_SUB_SET);
      {rx_feat, rx_lba} = {full_feat, full_lba - 64'h5};
      security_enabled <= 1'b0;
      hpa_established <= 1'b1;
      run(DCO_SUB_SET);
      hpa_established <= 1'b0;
      run(DCO_SUB_FREEZE);
      for (int i = 0; i < 5; i++)
         run(8'hc0 + 8'(i));
      restart(1'b1, 1'b0);
      run(DCO_SUB_SET);
      restart(1'b0, 1'b1);
      run(DCO_SUB_RESTORE);
      stop_test();
   end
endmodule
`default_nettype wire
